// *** logic/dsp_ctrl_defines.vh ***
// constants for the core control register group: offsets, fields, timing
// assumes 12-bit control-port locations and 16-bit register words
`ifndef DSP_CTRL_DEFINES_VH
`define DSP_CTRL_DEFINES_VH

`define OFS_LOAD_TARGET_0 12'h815
`define OFS_LOAD_TARGET_4 12'h819
`define OFS_NODE_CAPTURE_0 12'h81A
`define OFS_NODE_CAPTURE_1 12'h81B
`define OFS_CORE_CONTROL 12'h81C

`define LOAD_TARGET_RESET 12'h000
`define CORE_CONTROL_RESET 16'h0000
`define CORE_CONTROL_MASK 16'h31FF
`define CAPTURE_SETUP_RESET 12'h000

`define CC_DEBOUNCE_HI 13
`define CC_DEBOUNCE_LO 12
`define CC_AUX_HOST_WRITE 8
`define CC_PIN_HOST_WRITE 7
`define CC_IF_HOST_WRITE 6
`define CC_BEGIN_TRANSFER 5
`define CC_INPUT_UNMUTE 4
`define CC_OUTPUT_UNMUTE 3
`define CC_CORE_RUN 2
`define CC_RATE_HI 1
`define CC_RATE_LO 0

`define SETUP_STEP_HI 11
`define SETUP_STEP_LO 2
`define SETUP_SEL_HI 1
`define SETUP_SEL_LO 0

`define SEL_MULT_X 2'h0
`define SEL_MULT_Y 2'h1
`define SEL_MULT_ACCUM_RESULT 2'h2
`define SEL_ACC_FBACK 2'h3

`define DEB_CODE_20 2'h0
`define DEB_CODE_40 2'h1
`define DEB_CODE_10 2'h2
`define DEB_20_MS 6'h14
`define DEB_40_MS 6'h28
`define DEB_10_MS 6'h0A

`define CLK_PERIOD_NS 4
`define MS_IN_NS 1000000

`endif

// *** logic/node_capture_unit.v ***
// one capture channel: samples a chosen datapath word at a chosen step
// assumes step_index is the core program counter, valid with step_valid
`timescale 1ns/100ps
`default_nettype none
`include "dsp_ctrl_defines.vh"

module node_capture_unit (
	input wire mclk,
	input wire srst,
	input wire step_valid,
	input wire [9:0] step_index,
	input wire [11:0] setup,
	input wire [27:0] mult_x_operand,
	input wire [27:0] mult_y_operand,
	input wire [27:0] mult_accum_result,
	input wire [27:0] accum_feedback,
	output reg [23:0] captured_q
);
	reg [27:0] picked;

	always @* begin
		case (setup[`SETUP_SEL_HI:`SETUP_SEL_LO])
			`SEL_MULT_X: picked = mult_x_operand;
			`SEL_MULT_Y: picked = mult_y_operand;
			`SEL_MULT_ACCUM_RESULT: picked = mult_accum_result;
			default: picked = accum_feedback;
		endcase
	end

	always @(posedge mclk) begin
		if (srst) begin
			captured_q <= 24'h000000;
		end else if (step_valid &&
				step_index == setup[`SETUP_STEP_HI:`SETUP_STEP_LO]) begin
			// drop four fraction bits, 5.19 result
			captured_q <= picked[27:4];
		end
	end
endmodule
`default_nettype wire

// *** logic/dsp_capture_safeload_control.v ***
// control-port register group: deferred-load targets, captures, core control
// assumes a synchronous single-cycle register port and a frame enable pulse
`timescale 1ns/100ps
`default_nettype none
`include "dsp_ctrl_defines.vh"

// Function
// - five deferred-load target registers, each reset to zero.
// - two independent readable capture registers sampling any program node.
// - capture step count spans program steps 0 to 1023.
// - copy selected datapath word when program counter equals capture step.
// - setup word holds step in bits 11:2, select in 1:0, rest zero.
// - select 00 mult X, 01 mult Y, 10 MAC result, 11 accumulator feedback.
// - captured values are two's complement 5.19 fixed point.
// - captured value is the 28-bit 5.23 word minus four LSBs.
// - captures read at locations 2074 and 2075.
// - debounce codes 00 20 ms, 01 40 ms, 10 10 ms.
// - 16-bit core control register resets to zero with given layout.
// - target register n pairs with data register n, in order.
// - transfer moves only pairs written since the previous transfer.
// - begin-transfer bit clears itself when transfer completes.
// - transfer completes within one audio frame after begin is set; here it ends 5 cycles after the first frame tick seen while waiting.
module dsp_capture_safeload_control #(
	parameter MS_CYCLES = `MS_IN_NS / `CLK_PERIOD_NS,
	parameter PIN_COUNT = 12
) (
	input wire mclk,
	input wire srst,
	input wire [11:0] reg_addr,
	input wire reg_wr,
	input wire [15:0] reg_wdata,
	input wire reg_rd,
	output reg [23:0] reg_rdata_q,
	output reg reg_rvalid_q,
	input wire [4:0] load_data_written,
	input wire frame_tick,
	input wire step_valid,
	input wire [9:0] step_index,
	input wire [27:0] mult_x_operand,
	input wire [27:0] mult_y_operand,
	input wire [27:0] mult_accum_result,
	input wire [27:0] accum_feedback,
	input wire [PIN_COUNT-1:0] pin_in,
	output reg [PIN_COUNT-1:0] pin_debounced_q,
	output reg [15:0] core_control_q,
	output reg ram_load_valid_q,
	output reg [2:0] ram_load_slot_q,
	output reg [11:0] ram_load_addr_q
);
	localparam ST_IDLE = 3'b001;
	localparam ST_WAIT = 3'b010;
	localparam ST_LOAD = 3'b100;
	// the tick counter is 18 bits: more than 262144 cycles per ms won't fit
	localparam [31:0] MS_LAST_W = MS_CYCLES - 1;
	localparam [17:0] MS_LAST = MS_LAST_W[17:0];

	reg [11:0] target_q [0:4];
	reg [4:0] pending_q;
	reg [11:0] setup_q [0:1];
	wire [23:0] captured [0:1];
	reg [2:0] state_q;
	reg [2:0] slot_q;
	reg [17:0] ms_cnt_q;
	reg ms_tick_q;
	reg [5:0] deb_limit;
	reg [23:0] rd_d;
	wire wr_ctrl = reg_wr && reg_addr == `OFS_CORE_CONTROL;
	wire load_done = state_q == ST_LOAD && slot_q == 3'h4;
	wire [11:0] rd_ofs = reg_addr - `OFS_LOAD_TARGET_0;

	genvar g;
	generate
		for (g = 0; g < 5; g = g + 1) begin : g_slot
			wire [31:0] idx = g;
			wire [11:0] ofs = `OFS_LOAD_TARGET_0 + idx[11:0];
			wire hit = reg_wr && reg_addr == ofs;
			wire sent = state_q == ST_LOAD && slot_q == idx[2:0];
			always @(posedge mclk) begin
				if (srst) begin
					target_q[g] <= `LOAD_TARGET_RESET;
					pending_q[g] <= 1'b0;
				end else begin
					// only the 12 address bits are stored
					if (hit)
						target_q[g] <= reg_wdata[11:0];
					// a fresh write wins over the send clear
					if (hit || load_data_written[g])
						pending_q[g] <= 1'b1;
					else if (sent)
						pending_q[g] <= 1'b0;
				end
			end
		end
		for (g = 0; g < 2; g = g + 1) begin : g_cap
			wire [31:0] idx = g;
			wire [11:0] ofs = `OFS_NODE_CAPTURE_0 + idx[11:0];
			always @(posedge mclk) begin
				if (srst)
					setup_q[g] <= `CAPTURE_SETUP_RESET;
				// step and select packed in the low 12 bits
				else if (reg_wr && reg_addr == ofs)
					setup_q[g] <= reg_wdata[11:0];
			end
			node_capture_unit u_cap (
				.mclk(mclk),
				.srst(srst),
				.step_valid(step_valid),
				.step_index(step_index),
				.setup(setup_q[g]),
				.mult_x_operand(mult_x_operand),
				.mult_y_operand(mult_y_operand),
				.mult_accum_result(mult_accum_result),
				.accum_feedback(accum_feedback),
				.captured_q(captured[g])
			);
		end
	endgenerate

	always @(posedge mclk) begin
		if (srst) begin
			core_control_q <= `CORE_CONTROL_RESET;
		end else if (wr_ctrl) begin
			core_control_q <= reg_wdata & `CORE_CONTROL_MASK;
		end else if (load_done) begin
			// begin bit self-clears once the last slot is sent
			core_control_q[`CC_BEGIN_TRANSFER] <= 1'b0;
		end
	end

	// transfer waits for a frame boundary so the core never sees a mix
	// of old and new coefficients inside one frame
	always @(posedge mclk) begin
		if (srst) begin
			state_q <= ST_IDLE;
			slot_q <= 3'h0;
			ram_load_valid_q <= 1'b0;
			ram_load_slot_q <= 3'h0;
			ram_load_addr_q <= 12'h000;
		end else begin
			ram_load_valid_q <= 1'b0;
			case (state_q)
				ST_IDLE: begin
					if (core_control_q[`CC_BEGIN_TRANSFER])
						state_q <= ST_WAIT;
				end
				ST_WAIT: begin
					// starts at the next frame, ends 5 cycles on
					if (frame_tick) begin
						state_q <= ST_LOAD;
						slot_q <= 3'h0;
					end
				end
				ST_LOAD: begin
					// slot n sends target n with data n
					if (pending_q[slot_q]) begin
						ram_load_valid_q <= 1'b1;
						ram_load_slot_q <= slot_q;
						ram_load_addr_q <= target_q[slot_q];
					end
					if (load_done)
						state_q <= ST_IDLE;
					else
						slot_q <= slot_q + 3'h1;
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	always @* begin
		case (core_control_q[`CC_DEBOUNCE_HI:`CC_DEBOUNCE_LO])
			`DEB_CODE_20: deb_limit = `DEB_20_MS;
			`DEB_CODE_40: deb_limit = `DEB_40_MS;
			`DEB_CODE_10: deb_limit = `DEB_10_MS;
			// reserved code falls back to 20 ms
			default: deb_limit = `DEB_20_MS;
		endcase
	end

	always @(posedge mclk) begin
		if (srst) begin
			ms_cnt_q <= 18'h00000;
			ms_tick_q <= 1'b0;
		end else begin
			ms_tick_q <= ms_cnt_q == MS_LAST;
			if (ms_cnt_q == MS_LAST)
				ms_cnt_q <= 18'h00000;
			else
				ms_cnt_q <= ms_cnt_q + 18'h00001;
		end
	end

	// pin change must hold for the whole interval; a glitch restarts it
	generate
		for (g = 0; g < PIN_COUNT; g = g + 1) begin : g_pin
			reg [5:0] cnt_q;
			always @(posedge mclk) begin
				if (srst) begin
					cnt_q <= 6'h00;
					pin_debounced_q[g] <= 1'b0;
				end else if (pin_in[g] == pin_debounced_q[g]) begin
					cnt_q <= 6'h00;
				end else if (ms_tick_q) begin
					if (cnt_q + 6'h01 >= deb_limit) begin
						pin_debounced_q[g] <= pin_in[g];
						cnt_q <= 6'h00;
					end else begin
						cnt_q <= cnt_q + 6'h01;
					end
				end
			end
		end
	endgenerate

	always @* begin
		rd_d = 24'h000000;
		if (reg_addr >= `OFS_LOAD_TARGET_0 &&
				reg_addr <= `OFS_LOAD_TARGET_4)
			rd_d = {12'h000, target_q[rd_ofs[2:0]]};
		// captures read at their own locations, 5.19 format
		if (reg_addr == `OFS_NODE_CAPTURE_0)
			rd_d = captured[0];
		if (reg_addr == `OFS_NODE_CAPTURE_1)
			rd_d = captured[1];
		if (reg_addr == `OFS_CORE_CONTROL)
			rd_d = {8'h00, core_control_q};
	end

	always @(posedge mclk) begin
		if (srst) begin
			reg_rdata_q <= 24'h000000;
			reg_rvalid_q <= 1'b0;
		end else begin
			reg_rvalid_q <= reg_rd;
			if (reg_rd)
				reg_rdata_q <= rd_d;
		end
	end
endmodule
`default_nettype wire

// *** tb/dsp_ctrl_props.sv ***
// port checks for the control register group
// assumes binding onto the design top module
`timescale 1ns/100ps
`default_nettype none
`include "dsp_ctrl_defines.vh"
module dsp_ctrl_props (
	input wire logic mclk,
	input wire logic srst,
	input wire logic [11:0] reg_addr,
	input wire logic reg_wr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_rd,
	input wire logic [23:0] reg_rdata_q,
	input wire logic reg_rvalid_q,
	input wire logic frame_tick,
	input wire logic [15:0] core_control_q,
	input wire logic ram_load_valid_q,
	input wire logic [2:0] ram_load_slot_q
);
	default clocking @(posedge mclk); endclocking
	default disable iff (srst);
	a_read_answer: assert property (reg_rd |=> reg_rvalid_q)
		else $error("read not answered");
	a_no_spurious: assert property (!reg_rd |=> !reg_rvalid_q)
		else $error("unrequested read answer");
	a_rdata_held: assert property (!reg_rd |=> $stable(reg_rdata_q))
		else $error("read data moved without a read");
	a_rsvd_zero: assert property (
		(core_control_q & ~`CORE_CONTROL_MASK) == 16'h0000)
		else $error("reserved control bit set");
	a_ctrl_write: assert property (
		reg_wr && reg_addr == `OFS_CORE_CONTROL |=>
		core_control_q == (`CORE_CONTROL_MASK & $past(reg_wdata)))
		else $error("control write not taken");
	a_slot_range: assert property (
		ram_load_valid_q |-> ram_load_slot_q <= 3'h4)
		else $error("load slot out of range");
	a_slot_order: assert property (
		ram_load_valid_q ##1 ram_load_valid_q |->
		ram_load_slot_q > $past(ram_load_slot_q))
		else $error("load slots out of order");
	a_begin_clears: assert property (
		frame_tick && core_control_q[5] && $past(core_control_q[5])
		|-> ##[1:8] !core_control_q[5])
		else $error("begin bit not cleared in time");
	c_load: cover property (ram_load_valid_q);
	c_clear: cover property ($fell(core_control_q[5]));
	c_read: cover property (reg_rd ##1 reg_rvalid_q);
endmodule
bind dsp_capture_safeload_control dsp_ctrl_props u_props (.mclk, .srst,
	.reg_addr, .reg_wr, .reg_wdata, .reg_rd, .reg_rdata_q, .reg_rvalid_q,
	.frame_tick, .core_control_q, .ram_load_valid_q, .ram_load_slot_q);
`default_nettype wire

// *** tb/host_port.sv ***
// host side of the control port: one-word writes and reads
// assumes the device answers a read one cycle after the strobe
`timescale 1ns/100ps
`default_nettype none
module host_port (
	input wire logic mclk,
	input wire logic [23:0] reg_rdata_q,
	output logic [11:0] reg_addr,
	output logic reg_wr,
	output logic [15:0] reg_wdata,
	output logic reg_rd
);
	initial begin
		reg_addr = 12'h000;
		reg_wr = 1'b0;
		reg_wdata = 16'h0000;
		reg_rd = 1'b0;
	end
	task automatic wr(input logic [11:0] a, input logic [15:0] v);
		@(posedge mclk);
		#1 reg_addr = a;
		reg_wdata = v;
		reg_wr = 1'b1;
		@(posedge mclk);
		#1 reg_wr = 1'b0;
		// released lines never keep stale values
		reg_wdata = ~v;
		reg_addr = ~a;
	endtask
	task automatic rd(input logic [11:0] a, output logic [23:0] v);
		@(posedge mclk);
		#1 reg_addr = a;
		reg_rd = 1'b1;
		@(posedge mclk);
		#1 reg_rd = 1'b0;
		reg_addr = ~a;
		@(posedge mclk);
		v = reg_rdata_q;
	endtask
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
// self-checking bench for the control register group
// assumes the host model in host_port.sv and a 4 ns core clock
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, a) begin num_checks++; if ((a) !== (e)) begin errors++; \
$display("CHECK FAILED %s exp %h got %h", n, e, a); end end
module tb_top;
	logic mclk, srst, reg_wr, reg_rd, reg_rvalid_q, frame_tick, step_valid;
	logic ram_load_valid_q;
	logic [2:0] ram_load_slot_q;
	logic [4:0] load_data_written;
	logic [9:0] step_index;
	logic [11:0] reg_addr, pin_in, pin_debounced_q, ram_load_addr_q;
	logic [15:0] reg_wdata, core_control_q;
	logic [23:0] reg_rdata_q, d;
	logic [27:0] w [4];
	logic [14:0] seen [$];
	int errors = 0, num_checks = 0, n;
	int lim [4] = '{20, 40, 10, 20};
	dsp_capture_safeload_control #(.MS_CYCLES(4), .PIN_COUNT(12)) dut (
		.mclk, .srst, .reg_addr, .reg_wr, .reg_wdata, .reg_rd,
		.reg_rdata_q, .reg_rvalid_q, .load_data_written, .frame_tick,
		.step_valid, .step_index, .mult_x_operand(w[0]),
		.mult_y_operand(w[1]), .mult_accum_result(w[2]),
		.accum_feedback(w[3]), .pin_in, .pin_debounced_q, .core_control_q,
		.ram_load_valid_q, .ram_load_slot_q, .ram_load_addr_q);
	host_port host (.mclk, .reg_rdata_q, .reg_addr, .reg_wr, .reg_wdata,
		.reg_rd);
	always @(posedge mclk) if (ram_load_valid_q)
		seen.push_back({ram_load_slot_q, ram_load_addr_q});
	task automatic conclude;
		if (errors == 0 && num_checks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task automatic xfer(input logic [4:0] p);
		@(posedge mclk);
		#1 load_data_written = p;
		@(posedge mclk);
		#1 load_data_written = 5'h00;
		seen.delete();
		host.wr(12'h81C, 16'h0020);
		repeat (3) @(posedge mclk);
		#1 frame_tick = 1'b1;
		@(posedge mclk);
		#1 frame_tick = 1'b0;
		repeat (12) @(posedge mclk);
		#1;
	endtask
	initial begin
		mclk = 1'b0;
		forever #2 mclk = ~mclk;
	end
	initial begin
		#100000;
		errors++;
		conclude();
	end
	initial begin
		srst = 1'b1;
		frame_tick = 1'b0;
		step_valid = 1'b0;
		step_index = 10'h000;
		load_data_written = 5'h00;
		pin_in = 12'h000;
		w = '{28'h8123456, 28'h7ABCDEF, 28'hF00000F, 28'h0FEDCBA};
		repeat (5) @(posedge mclk);
		#1 srst = 1'b0;
		for (int i = 0; i < 8; i++) begin
			host.rd(12'h815 + 12'(i), d);
			`CHK("reset value", 24'h000000, d);
		end
		for (int i = 0; i < 5; i++) begin
			host.wr(12'h815 + 12'(i), 16'hF0A0 + 16'(i));
			host.rd(12'h815 + 12'(i), d);
			`CHK("target", 24'h0000A0 + 24'(i), d);
		end
		host.wr(12'h81D, 16'hFFFF);
		host.rd(12'h81D, d);
		`CHK("unmapped", 24'h000000, d);
		host.wr(12'h81C, 16'hFFDF);
		host.rd(12'h81C, d);
		`CHK("control", 24'h0031DF, d);
		for (int c = 0; c < 4; c++) begin
			host.wr(12'h81C, 16'(c) << 12);
			@(posedge mclk);
			#1 pin_in = ~pin_in;
			n = 0;
			while (pin_debounced_q !== pin_in && n < 400) begin
				@(posedge mclk);
				#1 n++;
			end
			n -= lim[c] * 4;
			`CHK("debounce", 1'b1, n inside {[-6:6]});
		end
		for (int s = 0; s < 4; s++) begin
			host.wr(12'h81A + 12'(s % 2), {4'h0, 10'(s * 341), 2'(s)});
			@(posedge mclk);
			#1 step_valid = 1'b1;
			step_index = 10'(s * 341);
			@(posedge mclk);
			#1 step_valid = 1'b0;
			host.rd(12'h81A + 12'(s % 2), d);
			`CHK("capture", w[s][27:4], d);
		end
		// a neighbouring step, then the right step without valid
		@(posedge mclk);
		#1 w[2] = 28'h1234567;
		step_valid = 1'b1;
		step_index = 10'h2A9;
		@(posedge mclk);
		#1 step_valid = 1'b0;
		step_index = 10'h2AA;
		host.rd(12'h81A, d);
		`CHK("capture miss", 24'hF00000, d);
		// earlier target writes left every slot pending
		xfer(5'h00);
		`CHK("load all", 32'd5, 32'(seen.size()));
		for (int i = 0; i < 5; i++)
			`CHK("load pair", {3'(i), 12'h0A0 + 12'(i)}, seen[i]);
		xfer(5'h0A);
		`CHK("load count", 32'd2, 32'(seen.size()));
		`CHK("load first", {3'h1, 12'h0A1}, seen[0]);
		`CHK("load second", {3'h3, 12'h0A3}, seen[1]);
		`CHK("begin clear", 1'b0, core_control_q[5]);
		xfer(5'h00);
		`CHK("idle loads", 32'd0, 32'(seen.size()));
		host.wr(12'h81C, 16'h1010);
		`CHK("control set", 16'h1010, core_control_q);
		srst = 1'b1;
		repeat (2) @(posedge mclk);
		#1 srst = 1'b0;
		`CHK("reset control", 16'h0000, core_control_q);
		host.rd(12'h815, d);
		`CHK("reset target", 24'h000000, d);
		conclude();
	end
endmodule
`default_nettype wire
